// ---- tmc_pkg.sv ----
package tmc_pkg;
  localparam logic [7:0] ADR_MASK = 8'h39;
  localparam logic [7:0] ADR_FLAG = 8'h38;
  localparam logic [7:0] ADR_N_CNT = 8'h32;
  localparam logic [7:0] ADR_N_CMPA = 8'h36;
  localparam logic [7:0] ADR_N_CMPB = 8'h3C;
  localparam logic [7:0] ADR_N_CTRL = 8'h33;
  localparam logic [7:0] ADR_W_CTRLA = 8'h2F;
  localparam logic [7:0] ADR_W_CTRLB = 8'h2E;
  localparam logic [7:0] ADR_W_CNT = 8'h2C;
  localparam logic [7:0] ADR_W_CMPA = 8'h2A;
  localparam logic [7:0] ADR_W_CMPB = 8'h28;
  localparam logic [7:0] ADR_CAPT = 8'h24;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] RW_BITS = 8'hEF;
  localparam int B_W_OVF = 7;
  localparam int B_W_CMPA = 6;
  localparam int B_W_CMPB = 5;
  localparam int B_CAPT = 3;
  localparam int B_N_CMPB = 2;
  localparam int B_N_OVF = 1;
  localparam int B_N_CMPA = 0;
  localparam logic [15:0] W_BOTTOM = 16'h0000;
  localparam logic [15:0] W_MAX = 16'hFFFF;
  localparam logic [15:0] W_TOP8 = 16'h00FF;
  localparam logic [15:0] W_TOP9 = 16'h01FF;
  localparam logic [15:0] W_TOP10 = 16'h03FF;
  localparam logic [7:0] N_MAX = 8'hFF;
  localparam logic [7:0] N_BOTTOM = 8'h00;
  localparam int FILT_LEN = 4;
  // narrow ctrl: [2:0] wave mode, [6:4] clock select
  // wide ctrl a: [1:0] mode low, [2] capture from comparator, [3] cmp a pwm out
  // wide ctrl b: [7] filter, [6] rising edge, [4:3] mode high, [2:0] clock
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] capt;
  } tmc_wide_t;
endpackage : tmc_pkg

// ---- tmc_core.sv ----
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ns
module tmc_core #(
  parameter int PRE_DIV = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [7:0] dat_i,
  input wire logic we_i,
  input wire logic sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [7:0] dat_o,
  output logic ack_o,
  input wire logic global_irq_enable_i,
  input wire logic [7:0] vec_ack_i,
  input wire logic wide_ext_clock_pin_i,
  input wire logic capture_pin_i,
  input wire logic comparator_i,
  output logic [7:0] irq_req_o,
  output logic irq_o,
  output logic wide_wave_out_a_o,
  output logic wide_wave_out_b_o
);
  // refuse divides that the eight-bit prescaler cannot count
  if (PRE_DIV < 1 || PRE_DIV > 255) begin : g_bad_div
    $error("PRE_DIV out of range");
  end

  logic [7:0] mask_q, flag_q, n_cnt_q, n_cmpa_q, n_cmpb_q, n_ctrl_q;
  logic [7:0] w_ctrla_q, w_ctrlb_q;
  logic [7:0] n_cmpa_buf_q, n_cmpb_buf_q;
  tmc_pkg::tmc_wide_t w_q;
  logic [15:0] cmpa_buf_q, cmpb_buf_q;
  logic [7:0] pre_q;
  logic [1:0] ext_s_q, cap_s_q, cmp_s_q;
  logic ext_d_q, cap_lvl_q, cap_prev_q;
  logic [tmc_pkg::FILT_LEN-1:0] filt_q;
  logic [7:0] set_ev, rd_data;
  logic acc, wr, rd_flag, pre_tick, n_tick, w_tick, cap_edge;
  logic [3:0] w_mode;
  logic [15:0] w_top;
  logic w_pwm, w_top_a, w_top_c, n_pwm;
  logic [2:0] n_mode;

  // single-cycle answer, ack drops after one cycle
  assign acc = cyc_i && stb_i && !ack_o;
  assign wr = acc && we_i && sel_i;
  assign rd_flag = acc && !we_i && adr_i == tmc_pkg::ADR_FLAG;

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_o <= 1'b0;
    else ack_o <= acc;
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    case (adr_i)
      tmc_pkg::ADR_MASK: rd_data = mask_q & tmc_pkg::RW_BITS;
      tmc_pkg::ADR_FLAG: rd_data = flag_q & tmc_pkg::RW_BITS;
      tmc_pkg::ADR_N_CNT: rd_data = n_cnt_q;
      tmc_pkg::ADR_N_CMPA: rd_data = n_cmpa_buf_q;
      tmc_pkg::ADR_N_CMPB: rd_data = n_cmpb_buf_q;
      tmc_pkg::ADR_N_CTRL: rd_data = n_ctrl_q;
      tmc_pkg::ADR_W_CTRLA: rd_data = w_ctrla_q;
      tmc_pkg::ADR_W_CTRLB: rd_data = w_ctrlb_q;
      tmc_pkg::ADR_W_CNT: rd_data = w_q.cnt[7:0];
      tmc_pkg::ADR_W_CNT + 8'h01: rd_data = w_q.cnt[15:8];
      tmc_pkg::ADR_W_CMPA: rd_data = cmpa_buf_q[7:0];
      tmc_pkg::ADR_W_CMPA + 8'h01: rd_data = cmpa_buf_q[15:8];
      tmc_pkg::ADR_W_CMPB: rd_data = cmpb_buf_q[7:0];
      tmc_pkg::ADR_W_CMPB + 8'h01: rd_data = cmpb_buf_q[15:8];
      tmc_pkg::ADR_CAPT: rd_data = w_q.capt[7:0];
      tmc_pkg::ADR_CAPT + 8'h01: rd_data = w_q.capt[15:8];
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= 8'h00;
    else if (acc && !we_i) dat_o <= rd_data;
  end

  // control and buffer registers written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= tmc_pkg::MASK_RESET;
      n_ctrl_q <= 8'h00;
      w_ctrla_q <= 8'h00;
      w_ctrlb_q <= 8'h00;
      n_cmpa_buf_q <= 8'h00;
      n_cmpb_buf_q <= 8'h00;
      cmpa_buf_q <= 16'h0000;
      cmpb_buf_q <= 16'h0000;
    end else if (wr) begin
      case (adr_i)
        tmc_pkg::ADR_MASK: mask_q <= dat_i & tmc_pkg::RW_BITS;
        tmc_pkg::ADR_N_CTRL: n_ctrl_q <= dat_i;
        tmc_pkg::ADR_W_CTRLA: w_ctrla_q <= dat_i;
        tmc_pkg::ADR_W_CTRLB: w_ctrlb_q <= dat_i;
        tmc_pkg::ADR_N_CMPA: n_cmpa_buf_q <= dat_i;
        tmc_pkg::ADR_N_CMPB: n_cmpb_buf_q <= dat_i;
        tmc_pkg::ADR_W_CMPA: cmpa_buf_q[7:0] <= dat_i;
        tmc_pkg::ADR_W_CMPA + 8'h01: cmpa_buf_q[15:8] <= dat_i;
        tmc_pkg::ADR_W_CMPB: cmpb_buf_q[7:0] <= dat_i;
        tmc_pkg::ADR_W_CMPB + 8'h01: cmpb_buf_q[15:8] <= dat_i;
        default: ;
      endcase
    end
  end

  // pin synchronisers, two flops before any use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s_q <= 2'b00;
      cap_s_q <= 2'b00;
      cmp_s_q <= 2'b00;
      ext_d_q <= 1'b0;
    end else begin
      ext_s_q <= {ext_s_q[0], wide_ext_clock_pin_i};
      cap_s_q <= {cap_s_q[0], capture_pin_i};
      cmp_s_q <= {cmp_s_q[0], comparator_i};
      ext_d_q <= ext_s_q[1];
    end
  end

  // shared prescaler tick, fixed divide for both timers
  assign pre_tick = pre_q == 8'(PRE_DIV - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i) pre_q <= 8'h00;
    else pre_q <= pre_tick ? 8'h00 : pre_q + 8'h01;
  end

  // clock select: 0 stops, 1 system, 2..5 prescaled, 6 fall, 7 rise
  function automatic logic tick_sel(input logic [2:0] cs, input logic pt,
                                    input logic cur, input logic prv);
    case (cs)
      3'd0: tick_sel = 1'b0;
      3'd1: tick_sel = 1'b1;
      3'd6: tick_sel = prv && !cur;
      3'd7: tick_sel = cur && !prv;
      default: tick_sel = pt;
    endcase
  endfunction : tick_sel

  assign n_tick = tick_sel(n_ctrl_q[6:4], pre_tick, 1'b0, 1'b0);
  assign w_tick = tick_sel(w_ctrlb_q[2:0], pre_tick,
                           ext_s_q[1], ext_d_q);

  // narrow timer counts up; phase-correct modes not modelled, top per mode
  assign n_mode = n_ctrl_q[2:0];
  assign n_pwm = n_mode == 3'd1 || n_mode == 3'd3 || n_mode[2];
  logic [7:0] n_top;
  assign n_top = (n_mode == 3'd2 || n_mode[2]) ? n_cmpa_q : tmc_pkg::N_MAX;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      n_cnt_q <= 8'h00;
      n_cmpa_q <= 8'h00;
      n_cmpb_q <= 8'h00;
    end else begin
      if (wr && adr_i == tmc_pkg::ADR_N_CNT) n_cnt_q <= dat_i;
      else if (n_tick)
        n_cnt_q <= (n_cnt_q == n_top) ? 8'h00 : n_cnt_q + 8'h01;
      // pwm modes load compares at top, others immediately
      if (!n_pwm || (n_tick && n_cnt_q == n_top)) begin
        n_cmpa_q <= n_cmpa_buf_q;
        n_cmpb_q <= n_cmpb_buf_q;
      end
    end
  end

  // wide mode and top choice
  assign w_mode = {w_ctrlb_q[4:3], w_ctrla_q[1:0]};
  assign w_top_a = w_mode == 4'd4 || w_mode == 4'd9 || w_mode == 4'd11
                   || w_mode == 4'd15;
  assign w_top_c = w_mode == 4'd8 || w_mode == 4'd10 || w_mode == 4'd12
                   || w_mode == 4'd14;
  assign w_pwm = w_mode != 4'd0 && w_mode != 4'd4 && w_mode != 4'd12;
  always_comb begin
    case (w_mode[1:0])
      2'd1: w_top = tmc_pkg::W_TOP8;
      2'd2: w_top = tmc_pkg::W_TOP9;
      2'd3: w_top = tmc_pkg::W_TOP10;
      default: w_top = tmc_pkg::W_MAX;
    endcase
    if (w_top_a) w_top = w_q.cmp_a;
    else if (w_top_c) w_top = w_q.capt;
  end

  // capture path: optional four-sample filter, then edge detect
  logic cap_src;
  assign cap_src = w_ctrla_q[2] ? cmp_s_q[1] : cap_s_q[1];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_q <= '0;
      cap_lvl_q <= 1'b0;
      cap_prev_q <= 1'b0;
    end else begin
      filt_q <= {filt_q[tmc_pkg::FILT_LEN-2:0], cap_src};
      if (!w_ctrlb_q[7]) cap_lvl_q <= cap_src;
      else if (&filt_q || ~|filt_q) cap_lvl_q <= filt_q[0];
      cap_prev_q <= cap_lvl_q;
    end
  end
  assign cap_edge = !w_top_c && (w_ctrlb_q[6] ? (cap_lvl_q && !cap_prev_q)
                                              : (!cap_lvl_q && cap_prev_q));

  // wide counter, compares and capture; cpu write wins over counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_q <= '0;
    end else begin
      if (wr && adr_i == tmc_pkg::ADR_W_CNT) w_q.cnt[7:0] <= dat_i;
      else if (wr && adr_i == tmc_pkg::ADR_W_CNT + 8'h01)
        w_q.cnt[15:8] <= dat_i;
      else if (w_tick)
        w_q.cnt <= (w_q.cnt == w_top) ? tmc_pkg::W_BOTTOM : w_q.cnt + 16'h0001;
      // double buffer: pwm loads at top so top may change at run time
      if (!w_pwm || (w_tick && w_q.cnt == w_top)) begin
        w_q.cmp_a <= cmpa_buf_q;
        w_q.cmp_b <= cmpb_buf_q;
      end
      if (cap_edge) w_q.capt <= w_q.cnt;
      else if (w_top_c && wr && adr_i == tmc_pkg::ADR_CAPT)
        w_q.capt[7:0] <= dat_i;
      else if (w_top_c && wr && adr_i == tmc_pkg::ADR_CAPT + 8'h01)
        w_q.capt[15:8] <= dat_i;
    end
  end

  // hardware set events for each flag bit
  logic n_ovf;
  always_comb begin
    case (n_mode)
      3'd1, 3'd5: n_ovf = n_cnt_q == tmc_pkg::N_BOTTOM;
      3'd7: n_ovf = n_cnt_q == n_top;
      default: n_ovf = n_cnt_q == tmc_pkg::N_MAX;
    endcase
    set_ev = 8'h00;
    set_ev[tmc_pkg::B_N_CMPB] = n_tick && n_cnt_q == n_cmpb_q;
    set_ev[tmc_pkg::B_N_CMPA] = n_tick && n_cnt_q == n_cmpa_q;
    set_ev[tmc_pkg::B_N_OVF] = n_tick && n_ovf;
    set_ev[tmc_pkg::B_W_CMPA] = w_tick && w_q.cnt == w_q.cmp_a;
    set_ev[tmc_pkg::B_W_CMPB] = w_tick && w_q.cnt == w_q.cmp_b;
    set_ev[tmc_pkg::B_W_OVF] = w_tick && w_q.cnt == w_top;
    set_ev[tmc_pkg::B_CAPT] = cap_edge;
  end

  // flags: set beats clear by write-one, vector ack or read
  logic [7:0] clr;
  assign clr = (wr && adr_i == tmc_pkg::ADR_FLAG ? dat_i : 8'h00)
             | vec_ack_i
             | (rd_flag ? 8'hFF : 8'h00);
  always_ff @(posedge clk_i) begin
    if (rst_i) flag_q <= tmc_pkg::FLAG_RESET;
    else flag_q <= ((flag_q & ~clr) | set_ev)
                   & tmc_pkg::RW_BITS;
  end

  // requests per source and summary line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      irq_req_o <= global_irq_enable_i ? (mask_q & flag_q)
                                       : 8'h00;
      irq_o <= global_irq_enable_i && |(mask_q & flag_q);
    end
  end

  // waveform outputs toggle on match; compare a silent when it is pwm top
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wide_wave_out_a_o <= 1'b0;
      wide_wave_out_b_o <= 1'b0;
    end else begin
      if (set_ev[tmc_pkg::B_W_CMPA] && !(w_pwm && w_top_a) && w_ctrla_q[3])
        wide_wave_out_a_o <= !wide_wave_out_a_o;
      if (set_ev[tmc_pkg::B_W_CMPB])
        wide_wave_out_b_o <= !wide_wave_out_b_o;
    end
  end

  a_set_over_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    set_ev[tmc_pkg::B_N_CMPA] |=> flag_q[tmc_pkg::B_N_CMPA])
    else $error("flag lost on same-cycle clear");
  a_reserved_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !flag_q[4] && !mask_q[4])
    else $error("reserved bit set");
  a_narrow_b_irq: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_req_o[tmc_pkg::B_N_CMPB] |-> $past(global_irq_enable_i)
      && $past(mask_q[tmc_pkg::B_N_CMPB]))
    else $error("narrow b request without enable");
  a_narrow_ovf_irq: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (global_irq_enable_i && mask_q[1] && flag_q[1]) |=> irq_req_o[1])
    else $error("narrow ovf request missing");
  a_narrow_a_irq: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !global_irq_enable_i |=> !irq_req_o[0])
    else $error("narrow a request with global off");
  // a vector taken in the same cycle may clear the flag lawfully
  a_write_one_clr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == tmc_pkg::ADR_FLAG && !dat_i[7] && flag_q[7]
      && !vec_ack_i[7]) |=> flag_q[7])
    else $error("write zero cleared flag");
  a_frozen_count: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (w_ctrlb_q[2:0] == 3'd0 && !wr) |=> $stable(w_q.cnt))
    else $error("wide counter moved with no clock");
  a_capture_copy: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cap_edge |=> w_q.capt == $past(w_q.cnt)
      && flag_q[tmc_pkg::B_CAPT])
    else $error("capture not taken");
  // every taken vector clears its flag unless a new event sets it again
  a_vector_clr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (vec_ack_i != 8'h00)
      |=> (flag_q & $past(vec_ack_i) & ~$past(set_ev)) == 8'h00)
    else $error("vector did not clear flag");
endmodule : tmc_core

// ---- tmc_cpu_model.sv ----
`timescale 1ns/1ns
module tmc_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [3:0] delay_i,
  input wire logic [7:0] irq_req_i,
  output logic [7:0] vec_ack_o
);
  logic [3:0] wait_q;
  logic [7:0] pick;
  // highest pending request wins, as with a fixed-priority vector table
  always_comb begin
    pick = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (irq_req_i[i]) pick = 8'h01 << i;
    end
  end
  // vector is taken delay_i + 1 cycles after a request; delay_i must cover the
  // registered request falling, or a stale request would be taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      wait_q <= 4'h0;
      vec_ack_o <= 8'h00;
    end else if (vec_ack_o != 8'h00) begin
      vec_ack_o <= 8'h00;
      wait_q <= 4'h0;
    end else if (pick != 8'h00 && wait_q >= delay_i) begin
      vec_ack_o <= pick;
    end else if (pick != 8'h00) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : tmc_cpu_model

// ---- tmc_core_test.sv ----
`timescale 1ns/1ns
module tmc_core_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [7:0] dat_i = 8'h00;
  logic we_i = 1'b0;
  logic sel_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic gie = 1'b0;
  logic cap_pin = 1'b0;
  logic ext_pin = 1'b0;
  logic cmp_pin = 1'b0;
  logic cpu_en = 1'b0;
  logic [3:0] cpu_dly = 4'h3;
  logic [7:0] dat_o, irq_req_o, vec_ack, m;
  logic ack_o, irq_o, wave_a, wave_b;
  logic [15:0] lfsr_q = 16'h7AA4;
  int fails = 0;
  int tests_run = 0;

  always #4 clk_i = ~clk_i;

  tmc_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .global_irq_enable_i(gie), .vec_ack_i(vec_ack),
    .wide_ext_clock_pin_i(ext_pin), .capture_pin_i(cap_pin),
    .comparator_i(cmp_pin), .irq_req_o(irq_req_o), .irq_o(irq_o),
    .wide_wave_out_a_o(wave_a), .wide_wave_out_b_o(wave_b));
  tmc_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .enable_i(cpu_en),
    .delay_i(cpu_dly), .irq_req_i(irq_req_o), .vec_ack_o(vec_ack));

  // galois step of a maximal 16-bit sequence
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction : next_rand
  // request expected from flags, mask and global enable
  function automatic logic [7:0] exp_req(input logic [7:0] f, k,
                                         input logic g);
    return f & k & 8'hEF & {8{g}};
  endfunction : exp_req

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; ack and data are taken at the edge that shows ack
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= 1'b1;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    q = dat_o;
    check({7'h00, ack_o}, 8'h01);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(a, 1'b1, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(a, 1'b0, 8'h00, q);
    check(q, e);
  endtask : rdc
  // a full lap of the narrow counter sets all three of its flags
  task automatic narrow_lap();
    lfsr_q = next_rand(lfsr_q);
    wr(tmc_pkg::ADR_N_CNT, 8'h00);
    wr(tmc_pkg::ADR_N_CMPA, lfsr_q[7:0]);
    wr(tmc_pkg::ADR_N_CMPB, lfsr_q[15:8]);
    wr(tmc_pkg::ADR_N_CTRL, 8'h10);
    repeat (300) @(posedge clk_i);
    wr(tmc_pkg::ADR_N_CTRL, 8'h00);
    repeat (3) @(posedge clk_i);
  endtask : narrow_lap
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // cuts a hang short well past the expected run length
  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(tmc_pkg::ADR_MASK, 8'h00);
    rdc(tmc_pkg::ADR_FLAG, 8'h00);
    rdc(8'h00, 8'h00);
    narrow_lap();
    rdc(tmc_pkg::ADR_FLAG, 8'h07);
    rdc(tmc_pkg::ADR_FLAG, 8'h00);
    // random mask and global enable against held flags
    narrow_lap();
    for (int i = 0; i < 12; i++) begin
      lfsr_q = next_rand(lfsr_q);
      m = lfsr_q[7:0];
      wr(tmc_pkg::ADR_MASK, m);
      gie <= lfsr_q[8];
      repeat (3) @(posedge clk_i);
      check(irq_req_o, exp_req(8'h07, m, lfsr_q[8]));
      check({7'h00, irq_o}, {7'h00, |exp_req(8'h07, m, lfsr_q[8])});
      rdc(tmc_pkg::ADR_MASK, m & 8'hEF);
    end
    // zero bits leave flags alone, a one clears only its own flag
    wr(tmc_pkg::ADR_MASK, 8'hFF);
    gie <= 1'b1;
    wr(tmc_pkg::ADR_FLAG, 8'h10);
    wr(tmc_pkg::ADR_FLAG, 8'h00);
    repeat (3) @(posedge clk_i);
    check(irq_req_o, 8'h07);
    wr(tmc_pkg::ADR_FLAG, 8'h02);
    repeat (3) @(posedge clk_i);
    check(irq_req_o, 8'h05);
    // the cpu takes both remaining vectors, which clears their flags
    lfsr_q = next_rand(lfsr_q);
    cpu_dly <= 4'h3 + {1'b0, lfsr_q[2:0]};
    cpu_en <= 1'b1;
    for (int n = 0; n < 60 && irq_req_o !== 8'h00; n++) @(posedge clk_i);
    cpu_en <= 1'b0;
    check(irq_req_o, 8'h00);
    rdc(tmc_pkg::ADR_FLAG, 8'h00);
    // frozen wide counter, then a capture of its value
    wr(tmc_pkg::ADR_W_CTRLB, 8'h40);
    wr(tmc_pkg::ADR_W_CNT, 8'h34);
    wr(tmc_pkg::ADR_W_CNT + 8'h01, 8'h12);
    repeat (20) @(posedge clk_i);
    rdc(tmc_pkg::ADR_W_CNT, 8'h34);
    rdc(tmc_pkg::ADR_W_CNT + 8'h01, 8'h12);
    cap_pin <= 1'b1;
    repeat (12) @(posedge clk_i);
    rdc(tmc_pkg::ADR_CAPT, 8'h34);
    rdc(tmc_pkg::ADR_CAPT + 8'h01, 8'h12);
    check(irq_req_o, 8'h08);
    wr(tmc_pkg::ADR_FLAG, 8'h08);
    // wrap through max and past both compare values
    wr(tmc_pkg::ADR_W_CNT, 8'hF0);
    wr(tmc_pkg::ADR_W_CNT + 8'h01, 8'hFF);
    wr(tmc_pkg::ADR_W_CMPA, 8'h05);
    wr(tmc_pkg::ADR_W_CMPB, 8'h08);
    wr(tmc_pkg::ADR_W_CTRLA, 8'h08);
    wr(tmc_pkg::ADR_W_CTRLB, 8'h01);
    repeat (40) @(posedge clk_i);
    wr(tmc_pkg::ADR_W_CTRLB, 8'h00);
    repeat (3) @(posedge clk_i);
    check(irq_req_o, 8'hE0);
    check({6'h00, wave_a, wave_b}, 8'h03);
    // one count per rising edge on the external clock pin
    wr(tmc_pkg::ADR_W_CNT, 8'h00);
    wr(tmc_pkg::ADR_W_CNT + 8'h01, 8'h00);
    wr(tmc_pkg::ADR_W_CTRLB, 8'h07);
    repeat (5) begin
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    rdc(tmc_pkg::ADR_W_CNT, 8'h05);
    // comparator through the filter; the source switch gives a falling
    // level, which rising-edge capture must ignore
    wr(tmc_pkg::ADR_W_CTRLB, 8'hC0);
    wr(tmc_pkg::ADR_W_CTRLA, 8'h04);
    repeat (8) @(posedge clk_i);
    cmp_pin <= 1'b1;
    repeat (12) @(posedge clk_i);
    rdc(tmc_pkg::ADR_CAPT, 8'h05);
    // write-one clears land while compare a keeps setting the same flag
    wr(tmc_pkg::ADR_N_CMPA, 8'h01);
    wr(tmc_pkg::ADR_N_CMPB, 8'h80);
    wr(tmc_pkg::ADR_N_CNT, 8'h00);
    wr(tmc_pkg::ADR_N_CTRL, 8'h12);
    repeat (6) wr(tmc_pkg::ADR_FLAG, 8'h01);
    wr(tmc_pkg::ADR_N_CTRL, 8'h00);
    rdc(tmc_pkg::ADR_FLAG, 8'hE9);
    complete_run();
  end
endmodule : tmc_core_test
